// File: slcps_host_model.sv
// Remote bus master model: hands decoded command frames to the selector
`timescale 1ns/100ps
`default_nettype none
module slcps_host_model (
    // Clock
    input  wire logic                    clock_in,
    // Frames toward the device
    output var  slcps_pkg::slcps_frame_t frame_out
);
    import slcps_pkg::*;
    logic [2:0] idle_q = 3'h0;
    logic       busy   = 1'b0;
    initial frame_out = '0;
    // ------------------------------------------------------------
    // Idle lines keep changing so a stale field never looks valid
    // ------------------------------------------------------------
    always @(posedge clock_in) begin
        idle_q <= idle_q + 3'h1;
        if (!busy) begin
            frame_out <= '{1'b0, slcps_proto_t'(idle_q[1:0]), idle_q[2]};
        end
    end
    // One frame after a settle gap, prompt or slow
    task automatic send(input slcps_proto_t p, input logic ok, input int gap);
        busy = 1'b1;
        repeat (gap + 1) @(posedge clock_in);
        frame_out <= '{1'b1, p, ok};
        @(posedge clock_in);
        frame_out.valid <= 1'b0;
        busy = 1'b0;
    endtask
endmodule
`default_nettype wire

// File: slcps_pkg.sv
// Shared constants and types for the serial line configuration and protocol selector
package slcps_pkg;
    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_HZ           = 40_000_000;
    localparam int MODE_TIMEOUT_S   = 10;
    localparam int MODE_TIMEOUT_CYC = CLK_HZ * MODE_TIMEOUT_S;
    localparam int DIV_W            = 19;
    localparam int BAUD_RATE [16]   = '{2400, 2400, 4800, 9600, 19200, 31250, 38400, 57600,
                                        100000, 115200, 230400, 110, 150, 300, 600, 1200};
    // ---------------------------------------------------------------
    // Register map and fields
    // ---------------------------------------------------------------
    localparam int          AXI_AW       = 4;
    localparam logic [3:0]  OFS_LINE_CFG = 4'h0;
    localparam logic [3:0]  OFS_PROTO    = 4'h4;
    localparam logic [3:0]  OFS_STATUS   = 4'h8;
    localparam logic [3:0]  OFS_SOFT_RST = 4'hc;
    localparam logic [7:0]  LINE_CFG_RST = 8'h06;
    localparam logic [7:0]  PORT_ONE     = 8'h01;
    localparam int          PORT_SEL_LSB = 8;
    localparam int          FMT_DATA7    = 7;
    localparam int          FMT_PAR      = 6;
    localparam int          FMT_ODD      = 5;
    localparam int          FMT_STOP2    = 4;
    localparam int          PSEL_LSB     = 0;
    localparam int          PPROTO_LSB   = 4;
    localparam int          ST_MODE_LSB  = 8;
    localparam int          ST_PROTO_LSB = 10;
    localparam int          ST_REJ_BIT   = 12;
    localparam int          ST_HALT_BIT  = 13;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    localparam logic [1:0]  SEL_AUTO     = 2'b00;
    localparam logic [1:0]  SEL_RAW      = 2'b01;
    localparam logic [1:0]  SEL_FIXED    = 2'b10;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {MODE_AUTO = 2'b00, MODE_LOCKED = 2'b01,
                              MODE_RAW = 2'b10, MODE_FIXED = 2'b11} slcps_mode_t;
    typedef enum logic [1:0] {PROTO_NATIVE = 2'b00, PROTO_MB_ASCII = 2'b01,
                              PROTO_MB_RTU = 2'b10, PROTO_HOSTLINK = 2'b11} slcps_proto_t;
    typedef struct packed {
        logic awvalid; logic [AXI_AW-1:0] awaddr; logic wvalid; logic [31:0] wdata;
        logic [3:0] wstrb; logic bready; logic arvalid; logic [AXI_AW-1:0] araddr; logic rready;
    } slcps_axi_req_t;
    typedef struct packed {
        logic awready; logic wready; logic bvalid; logic [1:0] bresp;
        logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } slcps_axi_rsp_t;
    typedef struct packed {
        logic valid; slcps_proto_t proto; logic check_ok;
    } slcps_frame_t;
    typedef struct packed {
        logic accept; logic check_err; logic reject;
    } slcps_cmd_t;
    typedef struct packed {
        logic data7; logic par_en; logic par_odd; logic stop2; logic [3:0] baud;
    } slcps_fmt_t;
    typedef struct packed {
        logic [7:0] line_cfg; slcps_fmt_t fmt; slcps_mode_t mode; slcps_proto_t lock_proto;
        logic halt; logic halt_seen; logic cfg_rej; logic [31:0] idle_cnt;
        logic [DIV_W-1:0] baud_cnt; logic baud_tick; slcps_cmd_t cmd;
        logic aw_have; logic [AXI_AW-1:0] awaddr; logic w_have; logic [31:0] wdata;
        logic [3:0] wstrb; slcps_axi_rsp_t rsp;
    } slcps_state_t;
endpackage

// File: slcps_top.sv
// Serial line configuration register, bit-rate divider and protocol mode selector
// Notes on behaviour
// - Config byte: high nibble format, low rate
// - 7/8 data, 1/2 stop, odd/even/none parity
// - Format bits: 7 data7, 6 parity, 5 odd, 4 stop2
// - Rate nibble maps to fixed baud table
// - Config write accepted only for port one
// - Config holds until rewritten; soft reset keeps it
// - Config is lost at power-on reset
// - Power-up default 38400, 8 data, none, 1
// - Halt jumper at startup blocks config writes
// - Four protocols recognised on the port
// - Power-on starts in autodetect mode
// - Recognised protocol locks the port
// - Failed check gives a protocol error answer; auto mode drops such a frame
// - Other protocols rejected while locked
// - Ten idle seconds return locked mode to auto
// - Power cycle always returns to autodetect
// - Raw mode: no interpretation, no answers
// - Fixed mode stays on one protocol
// - Rates up to 230.4k supported
// - Half-duplex: ignore receive while transmitting
`timescale 1ns/100ps
`default_nettype none
module slcps_top #(
    parameter int MODE_TIMEOUT_CYC_P = slcps_pkg::MODE_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic                   clock_in,
    input  wire logic                   sys_rst_in,
    // Register bus
    input  wire slcps_pkg::slcps_axi_req_t axi_req_in,
    output var  slcps_pkg::slcps_axi_rsp_t axi_rsp_out,
    // Link side
    input  wire logic                   startup_halt_jumper_in,
    input  wire logic                   tx_busy_in,
    input  wire slcps_pkg::slcps_frame_t rx_frame_in,
    // Results
    output var  slcps_pkg::slcps_cmd_t  cmd_out,
    output var  slcps_pkg::slcps_mode_t mode_out,
    output var  slcps_pkg::slcps_proto_t lock_proto_out,
    output var  slcps_pkg::slcps_fmt_t  line_fmt_out,
    output logic                        baud_tick_out
);
    import slcps_pkg::*;

    slcps_state_t s_q;
    slcps_state_t s_d;
    logic         wr_fire;
    logic         rx_seen;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic slcps_fmt_t decode(input logic [7:0] b);
        slcps_fmt_t f;
        f = '0;
        f.baud = b[3:0];
        if (!b[FMT_PAR] && b[FMT_ODD]) begin
            f.data7 = 1'b0;
        end else begin
            f.data7   = b[FMT_DATA7];
            f.par_en  = b[FMT_PAR];
            f.par_odd = b[FMT_ODD];
            f.stop2   = b[FMT_STOP2];
        end
        return f;
    endfunction

    function automatic logic [DIV_W-1:0] divisor(input logic [3:0] n);
        int r;
        r = BAUD_RATE[n];
        return DIV_W'((CLK_HZ + r / 2) / r);
    endfunction

    function automatic logic [31:0] read_reg(input logic [AXI_AW-1:0] a, input slcps_state_t s);
        logic [31:0] v;
        v = '0;
        case (a)
            OFS_LINE_CFG: begin
                v[7:0] = s.line_cfg;
                v[PORT_SEL_LSB +: 8] = PORT_ONE;
            end
            OFS_STATUS: begin
                v[7:0] = s.line_cfg;
                v[ST_MODE_LSB +: 2] = s.mode;
                v[ST_PROTO_LSB +: 2] = s.lock_proto;
                v[ST_REJ_BIT] = s.cfg_rej;
                v[ST_HALT_BIT] = s.halt;
            end
            OFS_PROTO: begin
                v[PSEL_LSB +: 2] = (s.mode == MODE_RAW) ? SEL_RAW :
                                   (s.mode == MODE_FIXED) ? SEL_FIXED : SEL_AUTO;
                v[PPROTO_LSB +: 2] = s.lock_proto;
            end
            default: v = '0;
        endcase
        return v;
    endfunction

    assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.rsp.bvalid;
    assign rx_seen = rx_frame_in.valid && !tx_busy_in;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.cmd = '0;
        s_d.baud_tick = 1'b0;
        // Startup jumper is sampled once after reset release
        if (!s_q.halt_seen) begin
            s_d.halt_seen = 1'b1;
            s_d.halt = startup_halt_jumper_in;
        end
        // Bit-rate enable divider
        if (s_q.baud_cnt == '0) begin
            s_d.baud_cnt = divisor(s_q.fmt.baud) - DIV_W'(1);
            s_d.baud_tick = 1'b1;
        end else begin
            s_d.baud_cnt = s_q.baud_cnt - DIV_W'(1);
        end
        // Protocol selector
        if (s_q.mode == MODE_LOCKED) begin
            s_d.idle_cnt = s_q.idle_cnt + 32'h1;
        end
        if (rx_seen) begin
            case (s_q.mode)
                MODE_AUTO: begin
                    if (rx_frame_in.check_ok) begin
                        s_d.mode = MODE_LOCKED;
                        s_d.lock_proto = rx_frame_in.proto;
                        s_d.idle_cnt = '0;
                        s_d.cmd.accept = 1'b1;
                    end
                end
                MODE_LOCKED, MODE_FIXED: begin
                    if (rx_frame_in.proto != s_q.lock_proto) begin
                        s_d.cmd.reject = 1'b1;
                    end else if (!rx_frame_in.check_ok) begin
                        s_d.cmd.check_err = 1'b1;
                    end else begin
                        s_d.cmd.accept = 1'b1;
                        s_d.idle_cnt = '0;
                    end
                end
                MODE_RAW: s_d.cmd = '0;
                default: s_d.mode = MODE_AUTO;
            endcase
        end else if (s_q.mode == MODE_LOCKED && s_q.idle_cnt >= 32'(MODE_TIMEOUT_CYC_P - 1)) begin
            s_d.mode = MODE_AUTO;
            s_d.idle_cnt = '0;
        end
        // Bus write and read channels
        if (axi_req_in.awvalid && s_q.rsp.awready) begin
            s_d.aw_have = 1'b1;
            s_d.awaddr = axi_req_in.awaddr;
        end
        if (axi_req_in.wvalid && s_q.rsp.wready) begin
            s_d.w_have = 1'b1;
            s_d.wdata = axi_req_in.wdata;
            s_d.wstrb = axi_req_in.wstrb;
        end
        if (s_q.rsp.bvalid && axi_req_in.bready) begin
            s_d.rsp.bvalid = 1'b0;
        end
        if (wr_fire) begin
            s_d.aw_have = 1'b0;
            s_d.w_have = 1'b0;
            s_d.rsp.bvalid = 1'b1;
            s_d.rsp.bresp = RESP_OKAY;
            case ({s_q.awaddr[AXI_AW-1:2], 2'b00})
                OFS_LINE_CFG: begin
                    if (s_q.halt || s_q.wstrb[1:0] != 2'b11 ||
                        s_q.wdata[PORT_SEL_LSB +: 8] != PORT_ONE) begin
                        s_d.cfg_rej = 1'b1;
                        s_d.rsp.bresp = RESP_SLVERR;
                    end else begin
                        s_d.line_cfg = s_q.wdata[7:0];
                        s_d.fmt = decode(s_q.wdata[7:0]);
                        s_d.baud_cnt = '0;
                    end
                end
                OFS_PROTO: begin
                    if (s_q.halt || !s_q.wstrb[0]) begin
                        s_d.cfg_rej = 1'b1;
                        s_d.rsp.bresp = RESP_SLVERR;
                    end else begin
                        s_d.idle_cnt = '0;
                        case (s_q.wdata[PSEL_LSB +: 2])
                            SEL_RAW: s_d.mode = MODE_RAW;
                            SEL_FIXED: begin
                                s_d.mode = MODE_FIXED;
                                s_d.lock_proto = slcps_proto_t'(s_q.wdata[PPROTO_LSB +: 2]);
                            end
                            default: s_d.mode = MODE_AUTO;
                        endcase
                    end
                end
                OFS_SOFT_RST: begin
                    // Soft reset returns a locked selector to auto and clears the error flag, never the line setting
                    if (s_q.wdata[0]) begin
                        s_d.cfg_rej = 1'b0;
                        if (s_q.mode == MODE_LOCKED) begin
                            s_d.mode = MODE_AUTO;
                        end
                        s_d.idle_cnt = '0;
                    end
                end
                default: s_d.rsp.bresp = RESP_SLVERR;
            endcase
        end
        if (s_q.rsp.rvalid && axi_req_in.rready) begin
            s_d.rsp.rvalid = 1'b0;
        end
        if (axi_req_in.arvalid && s_q.rsp.arready) begin
            s_d.rsp.rvalid = 1'b1;
            s_d.rsp.rdata = read_reg({axi_req_in.araddr[AXI_AW-1:2], 2'b00}, s_q);
            s_d.rsp.rresp = ({axi_req_in.araddr[AXI_AW-1:2], 2'b00} == OFS_SOFT_RST) ?
                            RESP_SLVERR : RESP_OKAY;
        end
        s_d.rsp.awready = !s_d.aw_have && !s_d.rsp.bvalid;
        s_d.rsp.wready  = !s_d.w_have && !s_d.rsp.bvalid;
        s_d.rsp.arready = !s_d.rsp.rvalid;
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
            s_q.line_cfg <= LINE_CFG_RST;
            s_q.fmt <= decode(LINE_CFG_RST);
            s_q.mode <= MODE_AUTO;
        end else begin
            s_q <= s_d;
        end
    end

    assign axi_rsp_out    = s_q.rsp;
    assign cmd_out        = s_q.cmd;
    assign mode_out       = s_q.mode;
    assign lock_proto_out = s_q.lock_proto;
    assign line_fmt_out   = s_q.fmt;
    assign baud_tick_out  = s_q.baud_tick;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    AST_RESET_DEFAULT: assert property ($past(sys_rst_in) |-> s_q.line_cfg == LINE_CFG_RST && s_q.mode == MODE_AUTO)
        else $error("Line config or mode not at power-up default");
    AST_LOCK_ON_FRAME: assert property (s_q.mode == MODE_AUTO && rx_seen && rx_frame_in.check_ok && !wr_fire
        |=> s_q.mode == MODE_LOCKED && s_q.lock_proto == $past(rx_frame_in.proto) && cmd_out.accept)
        else $error("Valid frame in auto mode did not lock");
    AST_REJECT_OTHER: assert property ((s_q.mode == MODE_LOCKED || s_q.mode == MODE_FIXED) && rx_seen
        && rx_frame_in.proto != s_q.lock_proto |=> cmd_out.reject && !cmd_out.accept)
        else $error("Foreign protocol not rejected");
    AST_CHECK_ERR: assert property (s_q.mode == MODE_LOCKED && rx_seen && rx_frame_in.proto == s_q.lock_proto
        && !rx_frame_in.check_ok |=> cmd_out.check_err && !cmd_out.accept)
        else $error("Failed check not reported");
    AST_TIMEOUT: assert property (s_q.mode == MODE_LOCKED && s_q.idle_cnt == 32'(MODE_TIMEOUT_CYC_P - 1)
        && !rx_seen && !wr_fire |=> s_q.mode == MODE_AUTO)
        else $error("Idle timeout did not return to auto");
    AST_IDLE_RESTART: assert property (cmd_out.accept && s_q.mode == MODE_LOCKED |-> s_q.idle_cnt == '0)
        else $error("Accepted command did not restart idle timer");
    AST_RAW_SILENT: assert property (s_q.mode == MODE_RAW |=> cmd_out == '0)
        else $error("Raw mode produced a protocol result");
    AST_FIXED_HOLDS: assert property (s_q.mode == MODE_FIXED && !wr_fire |=> s_q.mode == MODE_FIXED)
        else $error("Fixed mode left without a write");
    AST_PORT_SEL: assert property (wr_fire && s_q.awaddr == OFS_LINE_CFG
        && s_q.wdata[PORT_SEL_LSB +: 8] != PORT_ONE |=> $stable(s_q.line_cfg) && axi_rsp_out.bresp == RESP_SLVERR)
        else $error("Config write for another port took effect");
    AST_HALT_BLOCKS: assert property (s_q.halt && wr_fire |=> $stable(s_q.line_cfg) && $stable(s_q.mode))
        else $error("Config write accepted while halt jumper set");
    AST_RESERVED_FMT: assert property (!s_q.line_cfg[FMT_PAR] && s_q.line_cfg[FMT_ODD]
        |-> !line_fmt_out.data7 && !line_fmt_out.par_en && !line_fmt_out.stop2)
        else $error("Reserved format not mapped to 8N1");
    AST_HALF_DUPLEX: assert property (tx_busy_in && s_q.mode == MODE_AUTO && !wr_fire |=> s_q.mode == MODE_AUTO)
        else $error("Frame taken while transmitting");

    COV_LOCK: cover property (s_q.mode == MODE_AUTO ##1 s_q.mode == MODE_LOCKED);
    COV_TIMEOUT: cover property (s_q.mode == MODE_LOCKED ##1 s_q.mode == MODE_AUTO);
    COV_REJECT: cover property (cmd_out.reject);
    COV_CFG_WRITE: cover property (wr_fire ##1 $changed(s_q.line_cfg));
endmodule
`default_nettype wire

// File: slcps_top_bench.sv
// Self-checking bench for the line configuration and protocol selector
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end
module slcps_top_bench;
    import slcps_pkg::*;
    localparam int TMO = 200;
    localparam slcps_mode_t SEL_MODE [4] = '{MODE_AUTO, MODE_RAW, MODE_FIXED, MODE_AUTO};
    logic           clock_in;
    logic           sys_rst_in = 1'b1;
    logic           jmp        = 1'b0;
    logic           tx_busy    = 1'b0;
    slcps_axi_req_t req        = '0;
    slcps_axi_rsp_t rsp;
    slcps_frame_t   frame;
    slcps_cmd_t     cmd;
    slcps_mode_t    mode;
    slcps_proto_t   lproto;
    slcps_fmt_t     fmt;
    logic           tick;
    logic [35:0]    exp_q[$];
    int             bad_count  = 0;
    int             n_compared = 0;
    logic [31:0]    rng        = 32'h2828bede;

    slcps_top #(.MODE_TIMEOUT_CYC_P(TMO)) DUT (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .axi_req_in(req), .axi_rsp_out(rsp), .startup_halt_jumper_in(jmp), .tx_busy_in(tx_busy),
        .rx_frame_in(frame), .cmd_out(cmd), .mode_out(mode), .lock_proto_out(lproto),
        .line_fmt_out(fmt), .baud_tick_out(tick));
    slcps_host_model host (.clock_in(clock_in), .frame_out(frame));

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nxt();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction
    function automatic slcps_fmt_t fmt_of(logic [7:0] b);
        if (b[7:4] inside {4'h2, 4'h3, 4'ha, 4'hb}) return {4'h0, b[3:0]};
        return b;
    endfunction
    function automatic logic [31:0] st(logic [7:0] c, logic [1:0] m, logic [1:0] p, logic r, logic j);
        return {18'h0, j, r, p, m, c};
    endfunction
    task automatic reset_dut(logic j);
        sys_rst_in <= 1'b1;
        jmp <= j;
        repeat (10) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d, logic [3:0] s, logic [1:0] r);
        int t;
        t = 0;
        @(posedge clock_in);
        exp_q.push_back({2'd1, r, 32'h0});
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        do begin
            @(posedge clock_in);
            t++;
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
        end while (!(rsp.bvalid && req.bready) && t < 100);
        req.bready <= 1'b0;
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] d, logic [1:0] r);
        int t;
        t = 0;
        @(posedge clock_in);
        exp_q.push_back({2'd2, r, d});
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge clock_in);
            t++;
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
        end while (!(rsp.rvalid && req.rready) && t < 100);
        req.rready <= 1'b0;
    endtask
    task automatic fr(slcps_proto_t p, logic ok, logic busy, logic [2:0] e);
        @(posedge clock_in);
        if (e != 3'b000) exp_q.push_back({2'd3, 31'h0, e});
        tx_busy <= busy;
        host.send(p, ok, nxt() % 3);
        tx_busy <= 1'b0;
        repeat (2) @(posedge clock_in);
    endtask
    task automatic baud_chk(logic [3:0] b);
        time t0;
        wr(OFS_LINE_CFG, {16'h0, PORT_ONE, 4'h0, b}, 4'h3, RESP_OKAY);
        repeat (2) @(posedge tick);
        t0 = $time;
        @(posedge tick);
        `CHK(($time - t0) / 25, (CLK_HZ + BAUD_RATE[b] / 2) / BAUD_RATE[b])
    endtask
    // ------------------------------------------------------------
    // Result watcher takes the oldest note for each answer
    // ------------------------------------------------------------
    task automatic take(logic [35:0] g);
        if (exp_q.size() == 0) `CHK(g, 36'h0)
        else `CHK(g, exp_q.pop_front())
    endtask
    always @(posedge clock_in) begin
        if (!sys_rst_in) begin
            if (rsp.bvalid && req.bready) take({2'd1, rsp.bresp, 32'h0});
            if (rsp.rvalid && req.rready) take({2'd2, rsp.rresp, rsp.rdata});
            if (cmd !== 3'b000) take({2'd3, 31'h0, cmd});
        end
    end
    task automatic final_report();
        `CHK(exp_q.size(), 0)
        $display("Counts: compared=%0d mismatches=%0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #2ms;
        bad_count++;
        final_report();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        logic [7:0]   c;
        slcps_proto_t p;
        reset_dut(1'b0);
        `CHK(fmt, 8'h06)
        rd(OFS_STATUS, st(8'h06, MODE_AUTO, PROTO_NATIVE, 1'b0, 1'b0), RESP_OKAY);
        $display("test defaults done");
        for (int f = 0; f < 16; f++) begin
            c = {f[3:0], 4'(nxt())};
            wr(OFS_LINE_CFG, {16'h0, PORT_ONE, c}, 4'h3, RESP_OKAY);
            `CHK(fmt, fmt_of(c))
            rd(OFS_LINE_CFG, {16'h0, PORT_ONE, c}, RESP_OKAY);
        end
        baud_chk(4'ha);
        baud_chk(4'h6);
        $display("test formats done");
        wr(OFS_LINE_CFG, {16'h0, 8'h02, 8'h46}, 4'h3, RESP_SLVERR);
        wr(OFS_LINE_CFG, {16'h0, PORT_ONE, 8'h46}, 4'h1, RESP_SLVERR);
        rd(OFS_SOFT_RST, 32'h0, RESP_SLVERR);
        rd(OFS_STATUS, st(8'h06, MODE_AUTO, PROTO_NATIVE, 1'b1, 1'b0), RESP_OKAY);
        $display("test refusals done");
        for (int i = 0; i < 4; i++) begin
            p = slcps_proto_t'(i);
            fr(p, 1'b0, 1'b0, 3'b000);
            fr(p, 1'b1, 1'b1, 3'b000);
            `CHK(mode, MODE_AUTO)
            fr(p, 1'b1, 1'b0, 3'b100);
            `CHK({mode, lproto}, {MODE_LOCKED, p})
            fr(p, 1'b0, 1'b0, 3'b010);
            fr(slcps_proto_t'(2'(i + 1)), 1'b1, 1'b0, 3'b001);
            wr(OFS_SOFT_RST, 32'h1, 4'hf, RESP_OKAY);
            `CHK({mode, fmt}, {MODE_AUTO, 8'h06})
        end
        fr(PROTO_MB_RTU, 1'b1, 1'b0, 3'b100);
        repeat (TMO - 60) @(posedge clock_in);
        fr(PROTO_MB_RTU, 1'b1, 1'b0, 3'b100);
        repeat (TMO - 60) @(posedge clock_in);
        `CHK(mode, MODE_LOCKED)
        repeat (80) @(posedge clock_in);
        `CHK(mode, MODE_AUTO)
        $display("test autodetect done");
        for (int s = 0; s < 4; s++) begin
            p = slcps_proto_t'(2'(nxt()));
            wr(OFS_PROTO, {26'h0, p, 2'h0, s[1:0]}, 4'h1, RESP_OKAY);
            `CHK(mode, SEL_MODE[s])
            if (s == 1) fr(p, 1'b1, 1'b0, 3'b000);
            if (s == 2) begin
                fr(slcps_proto_t'(p + 2'h1), 1'b1, 1'b0, 3'b001);
                repeat (TMO + 20) @(posedge clock_in);
                `CHK({mode, lproto}, {MODE_FIXED, p})
                fr(p, 1'b1, 1'b0, 3'b100);
            end
        end
        $display("test selector done");
        fr(PROTO_NATIVE, 1'b1, 1'b0, 3'b100);
        wr(OFS_LINE_CFG, {16'h0, PORT_ONE, 8'hc4}, 4'h3, RESP_OKAY);
        reset_dut(1'b1);
        `CHK({mode, fmt}, {MODE_AUTO, 8'h06})
        wr(OFS_LINE_CFG, {16'h0, PORT_ONE, 8'hc4}, 4'h3, RESP_SLVERR);
        wr(OFS_PROTO, 32'h2, 4'h1, RESP_SLVERR);
        rd(OFS_STATUS, st(8'h06, MODE_AUTO, PROTO_NATIVE, 1'b1, 1'b1), RESP_OKAY);
        `CHK(fmt, 8'h06)
        reset_dut(1'b0);
        $display("test power cycle done");
        final_report();
    end
endmodule
`default_nettype wire
